/* File: hdl/oag_core.v */
// Function
// - immediate: one cycle, three if two words
// - immediate operand is sixteen bits wide
// - direct: second word is the address
// - data addresses are byte addresses
// - indirect picks one of eight registers
// - inc/dec by two words, one bytes
// - post-modify uses original value first
// - plain indirect keeps register unchanged
// - indexed form adds index register after
// - pointer premodified before accumulator select
// - partner is sixteen away in ring
// - byte store writes low eight bits
// - port 0x08 output drops upper byte
// - input stores port value at address
// - rounding multiply keeps rounded upper half
// - lookup copies program word to memory
// - byte load sets multiplier operand register
// - modifier codes none, dec, inc, string
// - mode fields from opcode low byte, next A field from bits 11:10
`include "oag_consts.vh"
module oag_core (
  // clock and reset
  input wire clk,
  input wire rstn,
  // instruction stream
  input wire instr_valid,
  input wire [3:0] op,
  input wire [16:0] opcode,
  input wire [15:0] imm_word,
  input wire imm_two_words,
  input wire [1:0] ap_sel,
  // accumulator file read
  input wire [15:0] acc_rdata,
  // data memory read
  input wire [15:0] dmem_rdata,
  // program memory read
  input wire [15:0] pmem_rdata,
  // i/o port read
  input wire [15:0] port_rdata,
  // status
  output reg busy_q,
  output reg [4:0] acc_sel_q,
  output reg [4:0] acc_partner_q,
  output reg [15:0] mr_q,
  output reg [15:0] ph_q,
  // data memory
  output reg [15:0] dmem_addr_q,
  output reg dmem_we_q,
  output reg dmem_byte_q,
  output reg [15:0] dmem_wdata_q,
  // program memory
  output reg [15:0] pmem_addr_q,
  // i/o port
  output reg [7:0] port_addr_q,
  output reg port_we_q,
  output reg [15:0] port_wdata_q
);
  // ==========================================
  // state machine, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state_q;
  reg [2:0] state_d;
  // eight address registers and four accumulator pointers
  reg [15:0] areg_q [0:7];
  reg [4:0] ap_q [0:3];
  // fields of the latched instruction
  reg [3:0] op_q;
  reg [2:0] rx_q;
  reg [1:0] pm_q;
  reg ind_q;

  // ==========================================
  // opcode field decode
  wire [2:0] f_am = opcode[`OAG_AM_MSB:`OAG_AM_LSB];
  wire [2:0] f_rx = opcode[`OAG_RX_MSB:`OAG_RX_LSB];
  wire [1:0] f_pm = opcode[`OAG_PM_MSB:`OAG_PM_LSB];
  wire [1:0] f_na = opcode[`OAG_NA_MSB:`OAG_NA_LSB];
  wire is_ind = (f_am == `OAG_AM_INDIRECT);
  wire is_imm_op = (op == `OAG_OP_MOVI) || (op == `OAG_OP_MRBYTE);
  wire is_byte = (op == `OAG_OP_BSTORE);

  // ring partner sixteen positions away
  function [4:0] partner;
    input [4:0] a;
    begin
      partner = a + `OAG_PARTNER_OFS;
    end
  endfunction

  // next pointer value for the premodify code
  function [4:0] ap_mod;
    input [4:0] a;
    input [1:0] na;
    begin
      case (na)
        `OAG_NA_DEC: ap_mod = a - 5'h01;
        `OAG_NA_INC: ap_mod = a + 5'h01;
        default: ap_mod = a;
      endcase
    end
  endfunction

  // ==========================================
  // address formation
  reg [15:0] eff_addr;
  reg [15:0] ptr_sel;
  always @* begin
    ptr_sel = areg_q[f_rx];
    eff_addr = imm_word;
    if (is_ind) begin
      eff_addr = ptr_sel;
    end
  end

  // post-modified pointer, computed for the latched register
  wire [15:0] ptr_next;
  oag_post_mod u_post (
    .ptr(areg_q[rx_q]),
    .index_register(areg_q[`OAG_IDX_REG]),
    .pm(pm_q),
    .byte_op(op_q == `OAG_OP_BSTORE),
    .ptr_next(ptr_next)
  );

  wire [4:0] ap_new = ap_mod(ap_q[ap_sel], f_na);

  wire [31:0] prod = mr_q * dmem_rdata + `OAG_ROUND_BIT;

  // ==========================================
  // next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (instr_valid && !(is_imm_op && !imm_two_words)) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================
  // datapath registers
  integer i;
  always @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      for (i = 0; i < 8; i = i + 1) begin
        areg_q[i] <= `OAG_R_RESET;
      end
      for (i = 0; i < 4; i = i + 1) begin
        ap_q[i] <= `OAG_AP_RESET;
      end
      op_q <= `OAG_OP_MOVI;
      rx_q <= 3'h0;
      pm_q <= `OAG_PM_NONE;
      ind_q <= 1'b0;
      busy_q <= 1'b0;
      acc_sel_q <= 5'h00;
      // partner of pointer zero sits half a ring away
      acc_partner_q <= `OAG_PARTNER_OFS;
      mr_q <= 16'h0000;
      ph_q <= 16'h0000;
      dmem_addr_q <= 16'h0000;
      dmem_we_q <= 1'b0;
      dmem_byte_q <= 1'b0;
      dmem_wdata_q <= 16'h0000;
      pmem_addr_q <= 16'h0000;
      port_addr_q <= 8'h00;
      port_we_q <= 1'b0;
      port_wdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      dmem_we_q <= 1'b0;
      port_we_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (instr_valid) begin
            ap_q[ap_sel] <= ap_new;
            acc_sel_q <= ap_new;
            acc_partner_q <= partner(ap_new);
            op_q <= op;
            rx_q <= f_rx;
            pm_q <= is_ind ? f_pm : `OAG_PM_NONE;
            ind_q <= is_ind;
            dmem_addr_q <= eff_addr;
            dmem_byte_q <= is_byte;
            busy_q <= state_d != ST_IDLE;
            if (op == `OAG_OP_MOVI) begin
              areg_q[f_rx] <= imm_word;
            end
            if (op == `OAG_OP_MRBYTE) begin
              mr_q <= {8'h00, imm_word[7:0]};
            end
            pmem_addr_q <= acc_rdata;
            port_addr_q <= imm_word[7:0];
          end
        end
        ST_WAIT: begin
          case (op_q)
            `OAG_OP_STORE: begin
              dmem_we_q <= 1'b1;
              dmem_wdata_q <= acc_rdata;
            end
            `OAG_OP_BSTORE: begin
              dmem_we_q <= 1'b1;
              dmem_wdata_q <= {8'h00, acc_rdata[7:0]};
            end
            `OAG_OP_IN: begin
              dmem_we_q <= 1'b1;
              dmem_wdata_q <= port_rdata;
            end
            `OAG_OP_OUT: begin
              port_we_q <= 1'b1;
              port_wdata_q <= (port_addr_q == `OAG_PORT_B) ?
                {8'h00, dmem_rdata[7:0]} : dmem_rdata;
            end
            `OAG_OP_ROUNDING_MULTIPLY: ph_q <= prod[31:16];
            `OAG_OP_LOOKUP: begin
              dmem_we_q <= 1'b1;
              dmem_wdata_q <= pmem_rdata;
            end
            default: dmem_we_q <= 1'b0;
          endcase
        end
        ST_DONE: begin
          if (ind_q) begin
            areg_q[rx_q] <= ptr_next;
          end
          busy_q <= 1'b0;
        end
        default: busy_q <= 1'b0;
      endcase
    end
  end
endmodule // oag_core

/* File: hdl/oag_consts.vh */
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
// ==========================================
// opcode field positions
`define OAG_PM_LSB 0
`define OAG_PM_MSB 1
`define OAG_RX_LSB 2
`define OAG_RX_MSB 4
`define OAG_AM_LSB 5
`define OAG_AM_MSB 7
`define OAG_NA_LSB 10
`define OAG_NA_MSB 11
// ==========================================
// addressing mode encodings (am field)
`define OAG_AM_DIRECT 3'h0
`define OAG_AM_INDIRECT 3'h3
// post-modify encodings (pm field)
`define OAG_PM_NONE 2'h0
`define OAG_PM_INC 2'h1
`define OAG_PM_DEC 2'h2
`define OAG_PM_IDX 2'h3
// accumulator pointer modifier (next A field)
`define OAG_NA_NONE 2'h0
`define OAG_NA_DEC 2'h1
`define OAG_NA_INC 2'h2
`define OAG_NA_STR 2'h3
// ==========================================
// operation codes on the op input
`define OAG_OP_MOVI 4'h0
`define OAG_OP_LOAD 4'h1
`define OAG_OP_STORE 4'h2
`define OAG_OP_BSTORE 4'h3
`define OAG_OP_IN 4'h4
`define OAG_OP_OUT 4'h5
`define OAG_OP_ROUNDING_MULTIPLY 4'h6
`define OAG_OP_LOOKUP 4'h7
`define OAG_OP_MRBYTE 4'h8
// ==========================================
// misc constants
`define OAG_IDX_REG 3'h5
`define OAG_WORD_STEP 16'h0002
`define OAG_BYTE_STEP 16'h0001
`define OAG_PARTNER_OFS 5'h10
`define OAG_PORT_B 8'h08
`define OAG_ROUND_BIT 32'h00008000
`define OAG_R_RESET 16'h0000
`define OAG_AP_RESET 5'h00
`endif

/* File: hdl/oag_post_mod.v */
`include "oag_consts.vh"
// ==========================================
// address register post-modification
module oag_post_mod (
  // current pointer and controls
  input wire [15:0] ptr,
  input wire [15:0] index_register,
  input wire [1:0] pm,
  input wire byte_op,
  // updated pointer
  output reg [15:0] ptr_next
);
  reg [15:0] step;
  always @* begin
    step = byte_op ? `OAG_BYTE_STEP : `OAG_WORD_STEP;
    ptr_next = ptr;
    case (pm)
      `OAG_PM_INC: ptr_next = ptr + step;
      `OAG_PM_DEC: ptr_next = ptr - step;
      `OAG_PM_IDX: ptr_next = ptr + index_register;
      default: ptr_next = ptr;
    endcase
  end
endmodule // oag_post_mod

/* File: bench/oag_core_asserts.sv */
`include "oag_consts.vh"
// ==========================================
// port-level checker for the address core
module oag_core_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction
  input wire logic instr_valid,
  input wire logic [3:0] op,
  input wire logic [16:0] opcode,
  input wire logic [15:0] imm_word,
  input wire logic imm_two_words,
  // watched outputs
  input wire logic busy_q,
  input wire logic [4:0] acc_sel_q,
  input wire logic [4:0] acc_partner_q,
  input wire logic [15:0] dmem_addr_q,
  input wire logic dmem_we_q,
  input wire logic dmem_byte_q,
  input wire logic [15:0] dmem_wdata_q,
  input wire logic [7:0] port_addr_q,
  input wire logic port_we_q,
  input wire logic [15:0] port_wdata_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // accepted request, then one that touches memory
  sequence s_take;
    instr_valid && !busy_q;
  endsequence
  sequence s_mem;
    s_take ##0 (op > `OAG_OP_MOVI && op < `OAG_OP_MRBYTE);
  endsequence
  imm_one_a: assert property (
    s_take ##0 (op == `OAG_OP_MOVI && !imm_two_words) |=> !busy_q)
    else $error("single word immediate raised busy");
  multi_busy_a: assert property (s_mem |=> busy_q)
    else $error("memory instruction not busy");
  direct_addr_a: assert property (
    s_mem ##0 (opcode[7:5] != `OAG_AM_INDIRECT && op != `OAG_OP_IN && op != `OAG_OP_OUT)
    |=> dmem_addr_q == $past(imm_word))
    else $error("direct address differs from second word");
  byte_hi_a: assert property (dmem_we_q && dmem_byte_q |-> dmem_wdata_q[15:8] == 8'h00)
    else $error("byte store upper byte not zero");
  port_hi_a: assert property (
    port_we_q && port_addr_q == `OAG_PORT_B |-> port_wdata_q[15:8] == 8'h00)
    else $error("narrow port got upper byte");
  partner_a: assert property (acc_partner_q == 5'(acc_sel_q + `OAG_PARTNER_OFS))
    else $error("partner not sixteen away");
  we_pulse_a: assert property ($rose(dmem_we_q) |-> busy_q ##1 !dmem_we_q)
    else $error("write pulse outside instruction");
  port_in_a: assert property (
    s_take ##0 op == `OAG_OP_IN ##1 busy_q |=> port_addr_q == $past(imm_word[7:0], 2))
    else $error("input port location wrong");
endmodule // oag_core_asserts

bind oag_core oag_core_asserts oag_core_asserts_inst (.clk, .rstn, .instr_valid, .op, .opcode,
  .imm_word, .imm_two_words, .busy_q, .acc_sel_q, .acc_partner_q, .dmem_addr_q, .dmem_we_q,
  .dmem_byte_q, .dmem_wdata_q, .port_addr_q, .port_we_q, .port_wdata_q);

/* File: bench/oag_mem_model.sv */
// ==========================================
// memories and ports, reads settle at once
module oag_mem_model (
  // addresses from the core
  input wire logic [15:0] dmem_addr_q,
  input wire logic [15:0] pmem_addr_q,
  input wire logic [7:0] port_addr_q,
  // read data
  output wire logic [15:0] dmem_rdata,
  output wire logic [15:0] pmem_rdata,
  output wire logic [15:0] port_rdata
);
  // address-derived data so a wrong address shows up as wrong data
  assign dmem_rdata = dmem_addr_q ^ 16'h5A3C;
  assign pmem_rdata = ~pmem_addr_q;
  assign port_rdata = {8'hC3, port_addr_q};
endmodule // oag_mem_model

/* File: bench/tb_operand_address_generation.sv */
`include "oag_consts.vh"
module tb_operand_address_generation;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, instr_valid = 0, imm_two_words = 0;
  logic busy_q, dmem_we_q, dmem_byte_q, port_we_q, bz = 0;
  logic [3:0] op = 0;
  logic [16:0] opcode = 0;
  logic [1:0] ap_sel = 0;
  logic [15:0] imm_word = 0, acc_rdata = 0, ac, v, x, a, dmem_rdata, pmem_rdata, port_rdata;
  logic [15:0] mr_q, ph_q, dmem_addr_q, dmem_wdata_q, pmem_addr_q, port_wdata_q;
  logic [4:0] acc_sel_q, acc_partner_q, k;
  logic [7:0] port_addr_q, b;
  logic [31:0] m;
  logic [15:0] aq[$], wq[$], pq[$];
  int errors = 0, check_count = 0;
  always #10 clk = ~clk;
  oag_core oag_core_inst (.clk, .rstn, .instr_valid, .op, .opcode, .imm_word, .imm_two_words,
    .ap_sel, .acc_rdata, .dmem_rdata, .pmem_rdata, .port_rdata, .busy_q, .acc_sel_q,
    .acc_partner_q, .mr_q, .ph_q, .dmem_addr_q, .dmem_we_q, .dmem_byte_q, .dmem_wdata_q,
    .pmem_addr_q, .port_addr_q, .port_we_q, .port_wdata_q);
  oag_mem_model oag_mem_model_inst (.dmem_addr_q, .pmem_addr_q, .port_addr_q, .dmem_rdata,
    .pmem_rdata, .port_rdata);
  // ==========================================
  // compare and closing
  task cmp(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one instruction; memory ops note the address they should present
  task automatic ex(input logic [3:0] o, input logic [16:0] oc, input logic [15:0] iw,
                    input logic [15:0] ea, input logic t);
    int n = 0;
    if (o > `OAG_OP_MOVI && o < `OAG_OP_MRBYTE) aq.push_back(ea);
    @(posedge clk);
    op <= o; opcode <= oc; imm_word <= iw; imm_two_words <= t; acc_rdata <= ac;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    do begin @(negedge clk); n++; end while (busy_q !== 1'b0 && n < 8);
    if (n >= 8) errors++;
  endtask
  // ==========================================
  // result watcher: address at busy rise, data at write pulses
  always @(posedge clk) begin
    bz <= busy_q;
    if (busy_q === 1'b1 && bz === 1'b0 && aq.size() > 0) cmp(aq.pop_front(), dmem_addr_q);
    if (dmem_we_q === 1'b1) cmp(wq.pop_front(), dmem_wdata_q);
    if (port_we_q === 1'b1) cmp(pq.pop_front(), port_wdata_q);
  end
  // watchdog well past the few hundred cycles used
  initial begin
    #200us;
    errors++;
    stop_test;
  end
  initial begin
    void'($urandom(60115));
    ap_sel <= 2'h2;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      x = $urandom;
      v = $urandom;
      ex(`OAG_OP_MOVI, 17'h14, x, 0, 0);
      ex(`OAG_OP_MOVI, 17'(r << 2), v, 0, r[0]);
      for (int p = 0; p < 4; p++) begin
        ex(`OAG_OP_LOAD, 17'h60 | 17'(r << 2) | 17'(p), 0, v, 0);
        v += p == 1 ? 16'h2 : p == 2 ? 16'hFFFE : p == 3 ? (r == 5 ? v : x) : 16'h0;
      end
      ex(`OAG_OP_LOAD, 17'h60 | 17'(r << 2), 0, v, 0);
    end
    // direct store at a doubled word address
    a = 16'($urandom) & 16'hFFFE;
    ac = $urandom;
    wq.push_back(ac);
    ex(`OAG_OP_STORE, 17'h0, a, a, 0);
    // byte store moves pointer by one
    wq.push_back({8'h00, ac[7:0]});
    ex(`OAG_OP_MOVI, 17'h1C, a, 0, 0);
    ex(`OAG_OP_BSTORE, 17'h7D, 0, a, 0);
    ex(`OAG_OP_LOAD, 17'h7C, 0, a + 16'h1, 0);
    wq.push_back(16'hC300);
    ex(`OAG_OP_MOVI, 17'h10, a, 0, 0);
    ex(`OAG_OP_IN, 17'h71, 16'h0000, a, 0);
    ex(`OAG_OP_LOAD, 17'h70, 0, a + 16'h2, 0);
    // narrow port keeps the low byte only
    pq.push_back({8'h00, a[7:0] ^ 8'h3C});
    ex(`OAG_OP_MOVI, 17'h04, a, 0, 0);
    ex(`OAG_OP_OUT, 17'h66, 16'h0008, a, 0);
    ex(`OAG_OP_LOAD, 17'h64, 0, a - 16'h2, 0);
    wq.push_back(~ac);
    ex(`OAG_OP_LOOKUP, 17'h0, a, a, 0);
    cmp(ac, pmem_addr_q);
    b = $urandom;
    ex(`OAG_OP_MRBYTE, {9'h0, b}, {8'h00, b}, 0, 0);
    cmp({8'h00, b}, mr_q);
    m = {24'h0, b} * {16'h0, a ^ 16'h5A3C} + `OAG_ROUND_BIT;
    ex(`OAG_OP_ROUNDING_MULTIPLY, 17'h0, a, a, 0);
    cmp(m[31:16], ph_q);
    // every modifier code, wrapping below zero
    k = 5'h00;
    // codes in order none, dec, inc, string: the first dec wraps to the top
    for (int i = 0; i < 6; i++) begin
      ex(`OAG_OP_LOAD, 17'(i % 4) << 10, a, a, 0);
      k += i % 4 == 1 ? 5'h1F : i % 4 == 2 ? 5'h01 : 5'h00;
      cmp({11'h0, k}, {11'h0, acc_sel_q});
      cmp({11'h0, 5'(k + 5'h10)}, {11'h0, acc_partner_q});
    end
    stop_test;
  end
endmodule // tb_operand_address_generation
